//--- flash_seq_pkg.sv
// Purpose: Shared constants of the flash command sequencer.
// Assumes: One 100 MHz clock, AHB-Lite register access, fixed flash geometry.
// Notes: Geometry figures are plain defaults for this controller build.
package flash_seq_pkg;
   // Register byte offsets within the slave window.
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_RESULT = 8'h0c;
   // Address bit that selects the page latch window; the latch repeats inside it.
   localparam int LATCH_SEL_BIT = 15;
   // Field positions of the mode and status registers.
   localparam int MODE_IRQ_EN_BIT = 0;
   localparam int MODE_WS_LSB = 8;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_CMDERR_BIT = 1;
   localparam int STAT_LOCKERR_BIT = 2;
   // Command register fields.
   localparam int KEY_LSB = 24;
   localparam int ARG_LSB = 8;
   localparam logic [7:0] CMD_KEY = 8'h5a;
   // Command codes.
   localparam logic [7:0] get_descriptor_cmd = 8'h00;
   localparam logic [7:0] write_page_cmd = 8'h01;
   localparam logic [7:0] write_then_lock_cmd = 8'h02;
   localparam logic [7:0] erase_then_write_cmd = 8'h03;
   localparam logic [7:0] erase_write_lock_cmd = 8'h04;
   localparam logic [7:0] wipe_whole_flash_cmd = 8'h05;
   localparam logic [7:0] plane_erase_cmd = 8'h06;
   localparam logic [7:0] set_region_lock_cmd = 8'h08;
   localparam logic [7:0] unlock_region_cmd = 8'h09;
   localparam logic [7:0] query_region_locks_cmd = 8'h0a;
   localparam logic [7:0] set_config_bit_cmd = 8'h0b;
   localparam logic [7:0] unset_config_bit_cmd = 8'h0c;
   localparam logic [7:0] query_config_bits_cmd = 8'h0d;
   localparam logic [7:0] start_unique_id_fetch_cmd = 8'h0e;
   localparam logic [7:0] stop_unique_id_fetch_cmd = 8'h0f;
   // Flash geometry.
   localparam int PAGE_WORDS = 64;
   localparam int PAGE_BYTES = 256;
   localparam int FLASH_PAGES = 2048;
   localparam int PLANES = 2;
   localparam int PAGES_PER_PLANE = 1024;
   localparam int LOCK_REGIONS = 16;
   localparam int PAGES_PER_REGION = 128;
   localparam int REGIONS_PER_PLANE = 8;
   localparam int NVM_BITS = 2;
   localparam int PAGE_W = 11;
   localparam int WORD_W = 6;
   // Descriptor length: four header words, planes, lock count, regions.
   localparam int DESC_LEN = 4 + PLANES + 1 + LOCK_REGIONS;
   // Arbitrary interface description value; not tied to any real part.
   localparam logic [31:0] DESC_IFACE_WORD = 32'h0000_0001;
   // Array busy time of one erase or program pass.
   localparam int OP_TIME_NS = 400;
   localparam int CLK_PERIOD_NS = 10;
   localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
   // Reset values.
   localparam logic [31:0] MODE_RESET = 32'h0000_0000;
   // Result source selectors and sequencer states.
   typedef enum logic [1:0] {RES_DESC, RES_LOCK, RES_NVM} res_kind_t;
   typedef enum {ST_IDLE, ST_ERASE, ST_PROG, ST_SETTLE, ST_FINISH} seq_state_t;
endpackage

//--- flash_command_sequencer.sv
// Purpose: Keyed command sequencer of an embedded flash controller on AHB-Lite.
// Assumes: Single AHB-Lite slave, word accesses only, one clock hclk.
// Notes: The array is driven through strobes; erase takes OP_CYCLES, program streams the page then settles OP_CYCLES.
// Behaviour
// - Codes 1-4 program page, with erase/lock variants.
// - Code 5 wipes all, 6 erases a plane.
// - Codes 8/9 set or clear region lock.
// - Codes A-F: lock query, config bits, unique-id.
// - Accepted command drops ready, zeroes result value.
// - Completion sets ready; enabled ready drives interrupt.
// - Unique-id start completes without setting ready.
// - Top byte carries the common command key.
// - Bad key or code sets command error.
// - Locked region write/erase refused, sets lock error.
// - Reads allowed only on planes not busy; here reads are never stalled or refused, plane_busy only reports.
// - Descriptor words read sequentially after ready.
// - Reads past last result word return zero.
// - Descriptor order: header, planes, lock count, regions.
// - One-page latch repeats across the address window.
// - Latch writes take configured read wait states.
// - Program starts at command write, ready cleared.
// - Erase before write, lock after write variants.
// - Partial passes use 128-bit aligned data; here every pass streams the whole 64-word latch.
// - Lock query returns all 16 lock bits in one word.
// - Reads stay open during lock bit commands.
// - Key value is 0x5A, else nothing starts.
// - Command write also clears both error flags.
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
module flash_command_sequencer
   import flash_seq_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic ready_irq,
   output logic [PLANES-1:0] plane_busy,
   output logic array_erase,
   output logic [1:0] array_erase_scope,
   output logic [PAGE_W-1:0] array_page,
   output logic array_word_we,
   output logic [WORD_W-1:0] array_word_idx,
   output logic [31:0] array_wdata,
   output logic unique_id_mode
);
   // Bus data-phase bookkeeping.
   logic dp_write;
   logic [15:0] dp_addr;
   logic [3:0] ws_cnt;
   // Software-visible state.
   logic [31:0] mode_reg;
   logic cmd_done_flag;
   logic cmd_error_flag;
   logic lock_violation_flag;
   logic [LOCK_REGIONS-1:0] lock_bits;
   logic [NVM_BITS-1:0] general_nonvolatile_bits;
   // Page latch storage.
   logic [31:0] latch_mem [PAGE_WORDS];
   // Sequencer state.
   seq_state_t state;
   logic [7:0] cur_code;
   logic [PAGE_W-1:0] cur_page;
   logic [15:0] op_cnt;
   logic [WORD_W-1:0] word_idx;
   logic cur_skip; // Refused or out-of-range command: no lock or bit change.
   // Result readout.
   res_kind_t res_kind;
   logic [4:0] res_idx;
   logic [4:0] res_len;

   // Decode of the request and of the data phase.
   logic take;
   logic rd_take;
   logic wr_commit;
   logic is_latch;
   logic cmd_wr;
   logic key_ok;
   logic code_ok;
   logic cmd_accept;
   logic [7:0] wr_code;
   logic [15:0] wr_arg;
   logic [3:0] wr_region;
   logic [0:0] wr_plane;
   logic wr_locked;
   logic plane_locked;
   logic status_rd;
   logic result_rd;
   logic [31:0] result_word;

   assign take = hsel & htrans[1] & hready;
   assign rd_take = take & ~hwrite;
   // The data phase ends on the edge where hready is high.
   assign wr_commit = dp_write & hready;
   assign is_latch = dp_addr[LATCH_SEL_BIT];
   assign cmd_wr = wr_commit & ~is_latch & (dp_addr[7:0] == ADDR_CMD);
   assign wr_code = hwdata[7:0];
   assign wr_arg = hwdata[ARG_LSB+15:ARG_LSB];
   assign key_ok = hwdata[31:KEY_LSB] == CMD_KEY;
   // Code 0x07 and anything above 0x0f are undefined.
   assign code_ok = (wr_code <= stop_unique_id_fetch_cmd) && (wr_code != 8'h07);
   assign cmd_accept = cmd_wr & key_ok & code_ok & (state == ST_IDLE);
   assign wr_region = wr_arg[PAGE_W-1:7];
   assign wr_plane = wr_arg[PAGE_W-1:PAGE_W-1];
   assign wr_locked = lock_bits[wr_region];
   assign plane_locked = wr_plane[0] ? (|lock_bits[15:8]) : (|lock_bits[7:0]);
   assign status_rd = rd_take & ~haddr[LATCH_SEL_BIT] & (haddr[7:0] == ADDR_STATUS);
   assign result_rd = rd_take & ~haddr[LATCH_SEL_BIT] & (haddr[7:0] == ADDR_RESULT);

   // Result word of the current query, picked by the read index.
   always_comb begin
      result_word = 32'h0000_0000;
      case (res_kind)
         RES_LOCK: begin
            result_word = {16'h0000, lock_bits};
         end
         RES_NVM: begin
            result_word = {30'h0000_0000, general_nonvolatile_bits};
         end
         default: begin
            // Header, per-plane sizes, lock count, then per-region sizes.
            if (res_idx == 5'h00) begin
               result_word = DESC_IFACE_WORD;
            end else if (res_idx == 5'h01) begin
               result_word = 32'(FLASH_PAGES * PAGE_BYTES);
            end else if (res_idx == 5'h02) begin
               result_word = 32'(PAGE_BYTES);
            end else if (res_idx == 5'h03) begin
               result_word = 32'(PLANES);
            end else if (res_idx < 5'(4 + PLANES)) begin
               result_word = 32'(PAGES_PER_PLANE * PAGE_BYTES);
            end else if (res_idx == 5'(4 + PLANES)) begin
               result_word = 32'(LOCK_REGIONS);
            end else begin
               result_word = 32'(PAGES_PER_REGION * PAGE_BYTES);
            end
         end
      endcase
   end

   // Address phase capture; held while wait states stretch the data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_addr <= 16'h0000;
      end else if (hready) begin
         dp_write <= take & hwrite;
         dp_addr <= haddr[15:0];
      end
   end

   // Latch writes wait the same count as configured for reads.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         ws_cnt <= 4'h0;
      end else if (take & hwrite & haddr[LATCH_SEL_BIT] & (mode_reg[11:8] != 4'h0)) begin
         hreadyout <= 1'b0;
         ws_cnt <= mode_reg[11:8];
      end else if (ws_cnt != 4'h0) begin
         ws_cnt <= ws_cnt - 4'h1;
         hreadyout <= ws_cnt == 4'h1;
      end
   end

   // Read data is prepared at the address edge; the response is always OKAY.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
      end else if (rd_take) begin
         hresp <= 1'b0;
         if (haddr[LATCH_SEL_BIT]) begin
            // The latch is write-only.
            hrdata <= 32'h0000_0000;
         end else begin
            case (haddr[7:0])
               ADDR_MODE: hrdata <= mode_reg;
               ADDR_STATUS: hrdata <= {29'h0000_0000, lock_violation_flag,
                                       cmd_error_flag, cmd_done_flag};
               ADDR_RESULT: hrdata <= (res_idx < res_len) ? result_word : 32'h0;
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Mode register: ready interrupt enable and wait-state count.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_reg <= MODE_RESET;
      end else if (wr_commit & ~is_latch & (dp_addr[7:0] == ADDR_MODE)) begin
         mode_reg <= {7'h00, hwdata[24], 7'h00, hwdata[16], 4'h0, hwdata[11:8], 7'h00,
                      hwdata[MODE_IRQ_EN_BIT]};
      end
   end

   // One latch word per generate entry; the page offset wraps every page.
   genvar gi;
   generate
      for (gi = 0; gi < PAGE_WORDS; gi++) begin : g_latch
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               latch_mem[gi] <= 32'h0000_0000;
            end else if (wr_commit & is_latch & (dp_addr[7:2] == WORD_W'(gi))) begin
               latch_mem[gi] <= hwdata;
            end else if (array_word_we & (array_word_idx == WORD_W'(gi))) begin
               // Back to erased ones once streamed, so a later partial pass is safe.
               latch_mem[gi] <= 32'hffff_ffff;
            end
         end
      end
   endgenerate

   // Error flags: the hardware set wins over a clear in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_error_flag <= 1'b0;
      end else if (cmd_wr & ~(key_ok & code_ok)) begin
         cmd_error_flag <= 1'b1;
      end else if (status_rd | cmd_wr) begin
         cmd_error_flag <= 1'b0;
      end
   end

   // Lock refusals are found when the command is accepted.
   logic lock_refuse;
   always_comb begin
      lock_refuse = 1'b0;
      case (wr_code)
         write_page_cmd, write_then_lock_cmd, erase_then_write_cmd,
         erase_write_lock_cmd: lock_refuse = wr_locked;
         wipe_whole_flash_cmd: lock_refuse = |lock_bits;
         plane_erase_cmd: lock_refuse = plane_locked;
         default: lock_refuse = 1'b0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_violation_flag <= 1'b0;
      end else if (cmd_accept & lock_refuse) begin
         lock_violation_flag <= 1'b1;
      end else if (status_rd | cmd_wr) begin
         lock_violation_flag <= 1'b0;
      end
   end

   // Command sequencer.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
         cur_code <= 8'h00;
         cur_page <= '0;
         op_cnt <= 16'h0000;
         word_idx <= '0;
         cur_skip <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cmd_accept) begin
                  cur_code <= wr_code;
                  cur_page <= wr_arg[PAGE_W-1:0];
                  cur_skip <= lock_refuse | (wr_arg >= 16'(FLASH_PAGES));
                  op_cnt <= 16'(OP_CYCLES);
                  word_idx <= '0;
                  if (lock_refuse | (wr_arg >= 16'(FLASH_PAGES))) begin
                     state <= ST_FINISH;
                  end else if (wr_code == erase_then_write_cmd ||
                               wr_code == erase_write_lock_cmd ||
                               wr_code == wipe_whole_flash_cmd ||
                               wr_code == plane_erase_cmd) begin
                     state <= ST_ERASE;
                  end else if (wr_code == write_page_cmd || wr_code == write_then_lock_cmd) begin
                     state <= ST_PROG;
                  end else begin
                     state <= ST_FINISH;
                  end
               end
            end
            ST_ERASE: begin
               op_cnt <= op_cnt - 16'h0001;
               if (op_cnt == 16'h0001) begin
                  op_cnt <= 16'(OP_CYCLES);
                  state <= (cur_code == erase_then_write_cmd ||
                            cur_code == erase_write_lock_cmd) ? ST_PROG : ST_FINISH;
               end
            end
            ST_PROG: begin
               // Stream the whole latch into the array, one word a cycle.
               word_idx <= word_idx + WORD_W'(1);
               if (word_idx == WORD_W'(PAGE_WORDS - 1)) begin
                  state <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               op_cnt <= op_cnt - 16'h0001;
               if (op_cnt == 16'h0001) begin
                  state <= ST_FINISH;
               end
            end
            ST_FINISH: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Ready flag: dropped on an accepted command, raised at finish except after a unique-id start.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_done_flag <= 1'b1;
      end else if (cmd_accept) begin
         cmd_done_flag <= 1'b0;
      end else if (state == ST_FINISH && cur_code != start_unique_id_fetch_cmd) begin
         cmd_done_flag <= 1'b1;
      end
   end

   // Interrupt follows the ready flag when enabled.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ready_irq <= 1'b0;
      end else begin
         ready_irq <= cmd_done_flag & mode_reg[MODE_IRQ_EN_BIT];
      end
   end

   // Lock bits and configuration bits change only at finish of a good command.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_bits <= '0;
         general_nonvolatile_bits <= '0;
         unique_id_mode <= 1'b0;
      end else if (state == ST_FINISH && !cur_skip) begin
         case (cur_code)
            set_region_lock_cmd, write_then_lock_cmd, erase_write_lock_cmd: begin
               lock_bits[cur_page[PAGE_W-1:7]] <= 1'b1;
            end
            unlock_region_cmd: lock_bits[cur_page[PAGE_W-1:7]] <= 1'b0;
            set_config_bit_cmd: begin
               if (cur_page < PAGE_W'(NVM_BITS)) begin
                  general_nonvolatile_bits[cur_page[0]] <= 1'b1;
               end
            end
            unset_config_bit_cmd: begin
               if (cur_page < PAGE_W'(NVM_BITS)) begin
                  general_nonvolatile_bits[cur_page[0]] <= 1'b0;
               end
            end
            start_unique_id_fetch_cmd: unique_id_mode <= 1'b1;
            stop_unique_id_fetch_cmd: unique_id_mode <= 1'b0;
            default: unique_id_mode <= unique_id_mode;
         endcase
      end
   end

   // Result readout: cleared by a command, loaded at finish, stepped by reads.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         res_kind <= RES_DESC;
         res_idx <= 5'h00;
         res_len <= 5'h00;
      end else if (cmd_accept) begin
         res_idx <= 5'h00;
         res_len <= 5'h00;
      end else if (state == ST_FINISH) begin
         case (cur_code)
            get_descriptor_cmd: begin
               res_kind <= RES_DESC;
               res_len <= 5'(DESC_LEN);
            end
            query_region_locks_cmd: begin
               res_kind <= RES_LOCK;
               res_len <= 5'h01;
            end
            query_config_bits_cmd: begin
               res_kind <= RES_NVM;
               res_len <= 5'h01;
            end
            default: res_len <= 5'h00;
         endcase
      end else if (result_rd && res_idx < res_len) begin
         res_idx <= res_idx + 5'h01;
      end
   end

   // Array strobes and per-plane busy; lock commands never block reads.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         array_erase <= 1'b0;
         array_erase_scope <= 2'h0;
         array_page <= '0;
         array_word_we <= 1'b0;
         array_word_idx <= '0;
         array_wdata <= 32'h0000_0000;
      end else begin
         array_erase <= state == ST_ERASE;
         array_erase_scope <= (cur_code == wipe_whole_flash_cmd) ? 2'h2 :
                              (cur_code == plane_erase_cmd) ? 2'h1 : 2'h0;
         array_page <= cur_page;
         array_word_we <= state == ST_PROG;
         array_word_idx <= word_idx;
         array_wdata <= latch_mem[word_idx];
      end
   end

   generate
      for (gi = 0; gi < PLANES; gi++) begin : g_plane
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               plane_busy[gi] <= 1'b0;
            end else begin
               plane_busy[gi] <= (state == ST_ERASE || state == ST_PROG ||
                                  state == ST_SETTLE) &&
                                 (cur_code == wipe_whole_flash_cmd ||
                                  cur_page[PAGE_W-1] == 1'(gi));
            end
         end
      end
   endgenerate

   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_BAD_KEY_ERR: assert property (cmd_wr & ~key_ok |=> cmd_error_flag)
      else $error("bad key did not set command error");
   AST_BAD_KEY_NOSTART: assert property (cmd_wr & ~key_ok & state == ST_IDLE
      |=> state == ST_IDLE)
      else $error("bad key started a command");
   AST_ACCEPT_DROP: assert property (cmd_accept |=> !cmd_done_flag && res_len == 5'h00)
      else $error("ready or result not cleared");
   AST_LOCK_REFUSE: assert property (cmd_accept & lock_refuse
      |=> lock_violation_flag && state == ST_FINISH)
      else $error("locked target not refused");
   AST_START_UNIQUE_ID_FETCH_CMD_LOW: assert property (state == ST_FINISH &&
      cur_code == start_unique_id_fetch_cmd |=> !cmd_done_flag)
      else $error("ready rose after unique id start");
   AST_FINISH_READY: assert property (state == ST_FINISH &&
      cur_code != start_unique_id_fetch_cmd |=> cmd_done_flag ##1
      (ready_irq == mode_reg[MODE_IRQ_EN_BIT]))
      else $error("ready or interrupt missing at completion");
   AST_BUSY_IGNORE: assert property (cmd_wr && state != ST_IDLE |=> $stable(cur_code))
      else $error("busy command disturbed");
   AST_PROG_LEN: assert property ($rose(state == ST_PROG) |-> (state == ST_PROG) [*8])
      else $error("program stream too short");
   AST_SLB_SETS: assert property (state == ST_FINISH &&
      cur_code == set_region_lock_cmd && !cur_skip |=> lock_bits[cur_page[PAGE_W-1:7]])
      else $error("lock bit not set");
   AST_LATCH_WS: assert property (take & hwrite & haddr[LATCH_SEL_BIT] &
      (mode_reg[11:8] == 4'h2) |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
      else $error("latch wait states wrong");

   COV_PROGRAM: cover property (state == ST_PROG ##[1:200] cmd_done_flag);
   COV_DESC_READ: cover property (result_rd && res_kind == RES_DESC && res_idx == 5'h05);
   COV_LOCK_ERR: cover property (cmd_accept & lock_refuse);
   COV_BAD_KEY: cover property (cmd_wr & ~key_ok);
endmodule

//--- flash_array_model.sv
// Purpose: Behavioural flash array that watches the sequencer's array strobes.
// Assumes: Strobes are registered on hclk and stand at least one cycle.
// Notes: Only counts, the last word and its index are kept; cell contents are not modelled.
module flash_array_model
   import flash_seq_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic array_erase,
   input wire logic array_word_we,
   input wire logic [31:0] array_wdata,
   input wire logic [WORD_W-1:0] array_word_idx,
   output int words_seen,
   output int erases_seen,
   output logic [31:0] last_word,
   output logic [WORD_W-1:0] last_idx
);
   timeunit 1ns;
   timeprecision 1ns;
   logic erase_d; // Erase level one cycle late, so each pass is counted once.
   // A refused command must leave both counts still, which the bench relies on.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         words_seen <= 0;
         erases_seen <= 0;
         erase_d <= 1'b0;
         last_word <= 32'h0;
         last_idx <= '0;
      end else begin
         erase_d <= array_erase;
         if (array_erase && !erase_d) erases_seen <= erases_seen + 1;
         if (array_word_we) begin
            words_seen <= words_seen + 1;
            last_word <= array_wdata;
            last_idx <= array_word_idx;
         end
      end
   end
endmodule

//--- testbench.sv
// Purpose: Self-checking bench of the flash command sequencer over AHB-Lite.
// Assumes: Mode bit0 is set, so ready_irq shows completion without status reads.
// Notes: Status reads clear the error flags, so completion is never polled there.
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
$display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench
   import flash_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ready_irq, array_erase;
   logic array_word_we, unique_id_mode;
   logic [1:0] htrans, array_erase_scope;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, array_wdata, r, last_word;
   logic [PLANES-1:0] plane_busy;
   logic [PAGE_W-1:0] array_page;
   logic [WORD_W-1:0] array_word_idx, last_idx;
   int fail_count = 0;
   int samples_checked = 0;
   int words_seen, erases_seen, i, w0, e0, waits;
   flash_command_sequencer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ready_irq(ready_irq),
      .plane_busy(plane_busy), .array_erase(array_erase), .array_erase_scope(array_erase_scope),
      .array_page(array_page), .array_word_we(array_word_we), .array_word_idx(array_word_idx),
      .array_wdata(array_wdata), .unique_id_mode(unique_id_mode));
   flash_array_model array_side (.hclk(hclk), .hresetn(hresetn), .array_erase(array_erase),
      .array_word_we(array_word_we), .array_wdata(array_wdata), .words_seen(words_seen),
      .erases_seen(erases_seen), .last_word(last_word), .array_word_idx(array_word_idx),
      .last_idx(last_idx));
   // One single word transfer; waits counts data-phase stall cycles.
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'b010;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      waits = -1;
      do begin
         @(posedge hclk);
         waits++;
      end while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic chk_rd(input string n, input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK(n, e, r)
   endtask
   // The flag drops one cycle before ready_irq does, so two edges pass first.
   task automatic cmd(input logic [7:0] c, input logic [15:0] arg);
      int n;
      n = 0;
      xfer(1'b1, {24'h0, ADDR_CMD}, {CMD_KEY, arg, c});
      repeat (2) @(posedge hclk);
      while (ready_irq !== 1'b1 && n < 400) begin
         @(posedge hclk);
         n++;
      end
      if (n >= 400) fail_count++;
   endtask
   function automatic logic [31:0] desc(input int k);
      if (k == 0) return DESC_IFACE_WORD;
      if (k == 1) return 32'(FLASH_PAGES * PAGE_BYTES);
      if (k == 2) return 32'(PAGE_BYTES);
      if (k == 3) return 32'(PLANES);
      if (k < 4 + PLANES) return 32'(PAGES_PER_PLANE * PAGE_BYTES);
      if (k == 4 + PLANES) return 32'(LOCK_REGIONS);
      if (k < DESC_LEN) return 32'(PAGES_PER_REGION * PAGE_BYTES);
      return 32'h0;
   endfunction
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      #200000;
      fail_count++;
      close_out();
   end
   initial begin
      {hresetn, hsel, htrans, haddr, hwrite, hsize, hwdata} = '0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk_rd("status at reset", {24'h0, ADDR_STATUS}, 32'h1);
      chk_rd("unmapped", 32'h10, 32'h0);
      xfer(1'b1, {24'h0, ADDR_MODE}, 32'h201);
      chk_rd("mode", {24'h0, ADDR_MODE}, 32'h201);
      cmd(get_descriptor_cmd, 16'h0);
      `CHK("ready irq", 1'b1, ready_irq)
      for (i = 0; i < DESC_LEN; i++) chk_rd("descr", {24'h0, ADDR_RESULT}, desc(i));
      chk_rd("past end", {24'h0, ADDR_RESULT}, 32'h0);
      for (i = 0; i < 2; i++) begin
         xfer(1'b1, {24'h0, ADDR_CMD}, i ? 32'h5a000007 : 32'ha5000001);
         repeat (4) @(posedge hclk);
         chk_rd("cmd error", {24'h0, ADDR_STATUS}, 32'h3);
         chk_rd("cmd error clear", {24'h0, ADDR_STATUS}, 32'h1);
      end
      cmd(get_descriptor_cmd, 16'h0);
      cmd(set_region_lock_cmd, 16'd5);
      chk_rd("result zeroed", {24'h0, ADDR_RESULT}, 32'h0);
      cmd(query_region_locks_cmd, 16'd0);
      chk_rd("lock bits", {24'h0, ADDR_RESULT}, 32'h1);
      w0 = words_seen;
      e0 = erases_seen;
      for (i = 0; i < 2; i++) begin
         cmd(i ? plane_erase_cmd : erase_then_write_cmd, 16'd5);
         chk_rd("lock error", {24'h0, ADDR_STATUS}, 32'h5);
      end
      `CHK("refused array", {w0, e0}, {words_seen, erases_seen})
      cmd(unlock_region_cmd, 16'd5);
      cmd(set_config_bit_cmd, 16'd1);
      cmd(query_config_bits_cmd, 16'd0);
      chk_rd("config bits", {24'h0, ADDR_RESULT}, 32'h2);
      for (i = 0; i < PAGE_WORDS; i++) xfer(1'b1, 32'h9000 + 32'(i * 4), 32'hc0de0000 + 32'(i));
      `CHK("latch wait", 2, waits)
      xfer(1'b1, {24'h0, ADDR_CMD}, {CMD_KEY, 16'd1029, erase_then_write_cmd});
      repeat (4) @(posedge hclk);
      `CHK("busy plane", 2'b10, plane_busy)
      cmd(8'h01, 16'h0);
      chk_rd("busy write ignored", {24'h0, ADDR_STATUS}, 32'h1);
      `CHK("page", {11'd1029, 2'h0, 1'b0}, {array_page, array_erase_scope, hresp})
      `CHK("words and erases", {w0 + 64, e0 + 1}, {words_seen, erases_seen})
      `CHK("last latch word", {32'hc0de003f, 6'h3f}, {last_word, last_idx})
      cmd(wipe_whole_flash_cmd, 16'h0);
      `CHK("wipe", e0 + 2, erases_seen)
      `CHK("wipe scope", 2'h2, array_erase_scope)
      xfer(1'b1, {24'h0, ADDR_CMD}, {CMD_KEY, 16'h0, start_unique_id_fetch_cmd});
      repeat (4) @(posedge hclk);
      chk_rd("uid ready low", {24'h0, ADDR_STATUS}, 32'h0);
      `CHK("uid on", 1'b1, unique_id_mode)
      cmd(stop_unique_id_fetch_cmd, 16'h0);
      chk_rd("uid stopped", {24'h0, ADDR_STATUS}, 32'h1);
      `CHK("uid off", 1'b0, unique_id_mode)
      close_out();
   end
endmodule
